// [core/tiopc_defs.vh]
// Constants for the thermal and input overvoltage protection register bank
`ifndef TIOPC_DEFS_VH
`define TIOPC_DEFS_VH

// ****************************************
// Register offsets
// ****************************************
`define TIOPC_ADDR_TEMP_CTRL     8'h0a
`define TIOPC_ADDR_DIE_ALARM     8'h0b
`define TIOPC_ADDR_BUS_THERM     8'h0c
`define TIOPC_ADDR_BAT_THERM     8'h0d
`define TIOPC_ADDR_OVP_CTRL      8'h0e
`define TIOPC_ADDR_CHG_CTRL2     8'h0f

// ****************************************
// Reset values
// ****************************************
`define TIOPC_RST_TEMP_CTRL      8'h60
`define TIOPC_RST_DIE_ALARM      8'hc8
`define TIOPC_RST_BUS_THERM      8'h15
`define TIOPC_RST_BAT_THERM      8'h15
`define TIOPC_RST_OVP_CTRL       8'h00

// ****************************************
// Field positions
// ****************************************
`define TIOPC_BIT_DIE_FLT_DIS    7
`define TIOPC_BIT_DIE_FLT_HI     6
`define TIOPC_BIT_DIE_FLT_LO     5
`define TIOPC_BIT_DIE_ALM_DIS    4
`define TIOPC_BIT_BUS_FLT_DIS    3
`define TIOPC_BIT_BAT_FLT_DIS    2
`define TIOPC_TEMP_WR_MASK       8'hfc
`define TIOPC_BIT_IN1_OVP_HI     7
`define TIOPC_BIT_IN1_OVP_LO     5
`define TIOPC_BIT_IN2_OVP_HI     4
`define TIOPC_BIT_IN2_OVP_LO     2
`define TIOPC_BIT_IN1_PD         1
`define TIOPC_BIT_IN2_PD         0
`define TIOPC_BIT_REG_RST        7

// ****************************************
// Die fault thresholds, alarm scale codes
// ****************************************
`define TIOPC_DIE_80C            8'h6e
`define TIOPC_DIE_100C           8'h96
`define TIOPC_DIE_120C           8'hbe
`define TIOPC_DIE_140C           8'he6

// ****************************************
// Input overvoltage levels in mV
// ****************************************
`define TIOPC_OVP_6V5            16'h1964
`define TIOPC_OVP_10V5           16'h2904
`define TIOPC_OVP_12V            16'h2ee0
`define TIOPC_OVP_14V            16'h36b0
`define TIOPC_OVP_16V            16'h3e80
`define TIOPC_OVP_18V            16'h4650

`endif

// [core/tiopc_ovp_cmp.v]
// Input overvoltage level decode and compare for one input
`default_nettype none

module tiopc_ovp_cmp (
    input  wire [2:0]  ovp_code_i,
    input  wire [15:0] voltage_mv_i,
    output wire        over_o
);
`include "tiopc_defs.vh"

    // ****************************************
    // Level decode
    // ****************************************
    function [15:0] ovp_level_mv;
        input [2:0] code;
        begin
            case (code)
                3'h0:    ovp_level_mv = `TIOPC_OVP_6V5;
                3'h1:    ovp_level_mv = `TIOPC_OVP_10V5;
                3'h2:    ovp_level_mv = `TIOPC_OVP_12V;
                3'h3:    ovp_level_mv = `TIOPC_OVP_14V;
                3'h4:    ovp_level_mv = `TIOPC_OVP_16V;
                // Undefined codes fall back to the safest, highest level
                default: ovp_level_mv = `TIOPC_OVP_18V;
            endcase
        end
    endfunction

    // Reaching the level counts, not only exceeding it
    assign over_o = (voltage_mv_i >= ovp_level_mv(ovp_code_i));

endmodule // tiopc_ovp_cmp
`default_nettype wire

// [core/tiopc_top.v]
// Thermal and input overvoltage protection register bank with its protection logic
`default_nettype none

module tiopc_top (
    input  wire        ref_clk_i,
    input  wire        nrst_i,
    input  wire [7:0]  reg_addr_i,
    input  wire [7:0]  reg_wdata_i,
    input  wire        reg_wr_i,
    input  wire        reg_rd_i,
    output reg  [7:0]  reg_rdata_o,
    output reg         reg_rvalid_o,
    input  wire [7:0]  die_temp_i,
    input  wire [7:0]  bus_therm_ratio_i,
    input  wire [7:0]  bat_therm_ratio_i,
    input  wire [15:0] input1_voltage_i,
    input  wire [15:0] input2_voltage_i,
    output reg         blocking_fet_off_o,
    output reg         switching_fet_off_o,
    output reg         charge_enable_clear_o,
    output reg         input1_gate_driver_off_o,
    output reg         input2_gate_driver_off_o,
    output reg         input1_pulldown_on_o,
    output reg         input2_pulldown_on_o,
    output reg         host_int_n_o,
    output reg         die_fault_o,
    output reg         bus_therm_fault_o,
    output reg         bat_therm_fault_o,
    output reg         reg_reset_done_o
);
`include "tiopc_defs.vh"

    // ****************************************
    // Register storage
    // ****************************************
    reg  [7:0] temp_protect_ctrl_q;
    reg  [7:0] die_alarm_threshold_q;
    reg  [7:0] bus_therm_fault_threshold_q;
    reg  [7:0] bat_therm_fault_threshold_q;
    reg  [7:0] input_ovp_ctrl_q;
    reg        any_fault_q;

    wire       wr_temp;
    wire       wr_alarm;
    wire       wr_bus;
    wire       wr_bat;
    wire       wr_ovp;
    wire       soft_reset;

    // ****************************************
    // Write decode
    // ****************************************
    assign wr_temp    = reg_wr_i && (reg_addr_i == `TIOPC_ADDR_TEMP_CTRL);
    assign wr_alarm   = reg_wr_i && (reg_addr_i == `TIOPC_ADDR_DIE_ALARM);
    assign wr_bus     = reg_wr_i && (reg_addr_i == `TIOPC_ADDR_BUS_THERM);
    assign wr_bat     = reg_wr_i && (reg_addr_i == `TIOPC_ADDR_BAT_THERM);
    assign wr_ovp     = reg_wr_i && (reg_addr_i == `TIOPC_ADDR_OVP_CTRL);
    // Reset bit lives in the charger control register next door; only it is seen here
    assign soft_reset = reg_wr_i && (reg_addr_i == `TIOPC_ADDR_CHG_CTRL2)
                        && reg_wdata_i[`TIOPC_BIT_REG_RST];

    always @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            temp_protect_ctrl_q         <= `TIOPC_RST_TEMP_CTRL;
            die_alarm_threshold_q       <= `TIOPC_RST_DIE_ALARM;
            bus_therm_fault_threshold_q <= `TIOPC_RST_BUS_THERM;
            bat_therm_fault_threshold_q <= `TIOPC_RST_BAT_THERM;
            input_ovp_ctrl_q            <= `TIOPC_RST_OVP_CTRL;
        end else if (soft_reset) begin
            temp_protect_ctrl_q         <= `TIOPC_RST_TEMP_CTRL;
            die_alarm_threshold_q       <= `TIOPC_RST_DIE_ALARM;
            bus_therm_fault_threshold_q <= `TIOPC_RST_BUS_THERM;
            bat_therm_fault_threshold_q <= `TIOPC_RST_BAT_THERM;
            input_ovp_ctrl_q            <= `TIOPC_RST_OVP_CTRL;
        end else begin
            if (wr_temp) begin
                // Low two bits are never stored
                temp_protect_ctrl_q <= reg_wdata_i & `TIOPC_TEMP_WR_MASK;
            end
            if (wr_alarm) begin
                die_alarm_threshold_q <= reg_wdata_i;
            end
            if (wr_bus) begin
                bus_therm_fault_threshold_q <= reg_wdata_i;
            end
            if (wr_bat) begin
                bat_therm_fault_threshold_q <= reg_wdata_i;
            end
            if (wr_ovp) begin
                input_ovp_ctrl_q <= reg_wdata_i;
            end
        end
    end

    // Reset bit reads back as zero: one-cycle pulse marks that it has cleared itself
    always @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reg_reset_done_o <= 1'b0;
        end else begin
            reg_reset_done_o <= soft_reset;
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    reg [7:0] rdata_d;

    always @* begin
        rdata_d = 8'h00;
        if (reg_addr_i == `TIOPC_ADDR_TEMP_CTRL) begin
            rdata_d = temp_protect_ctrl_q & `TIOPC_TEMP_WR_MASK;
        end else if (reg_addr_i == `TIOPC_ADDR_DIE_ALARM) begin
            rdata_d = die_alarm_threshold_q;
        end else if (reg_addr_i == `TIOPC_ADDR_BUS_THERM) begin
            rdata_d = bus_therm_fault_threshold_q;
        end else if (reg_addr_i == `TIOPC_ADDR_BAT_THERM) begin
            rdata_d = bat_therm_fault_threshold_q;
        end else if (reg_addr_i == `TIOPC_ADDR_OVP_CTRL) begin
            rdata_d = input_ovp_ctrl_q;
        end else begin
            rdata_d = 8'h00;
        end
    end

    always @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reg_rdata_o  <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) begin
                reg_rdata_o <= rdata_d;
            end
        end
    end

    // ****************************************
    // Die temperature protection
    // ****************************************
    function [7:0] die_fault_level;
        input [1:0] code;
        begin
            case (code)
                2'h0:    die_fault_level = `TIOPC_DIE_80C;
                2'h1:    die_fault_level = `TIOPC_DIE_100C;
                2'h2:    die_fault_level = `TIOPC_DIE_120C;
                default: die_fault_level = `TIOPC_DIE_140C;
            endcase
        end
    endfunction

    wire [1:0] die_fault_code;
    wire       die_fault_d;
    wire       die_alarm_d;
    wire       bus_fault_d;
    wire       bat_fault_d;
    wire       fault_d;

    assign die_fault_code = temp_protect_ctrl_q[`TIOPC_BIT_DIE_FLT_HI:`TIOPC_BIT_DIE_FLT_LO];
    // Measured die code uses the alarm scale: 25 C plus 0.5 C per step
    assign die_fault_d = !temp_protect_ctrl_q[`TIOPC_BIT_DIE_FLT_DIS]
                         && (die_temp_i >= die_fault_level(die_fault_code));
    assign die_alarm_d = !temp_protect_ctrl_q[`TIOPC_BIT_DIE_ALM_DIS]
                         && (die_temp_i >= die_alarm_threshold_q);

    // ****************************************
    // Thermistor ratio protection
    // ****************************************
    assign bus_fault_d = !temp_protect_ctrl_q[`TIOPC_BIT_BUS_FLT_DIS]
                         && (bus_therm_ratio_i < bus_therm_fault_threshold_q);
    assign bat_fault_d = !temp_protect_ctrl_q[`TIOPC_BIT_BAT_FLT_DIS]
                         && (bat_therm_ratio_i < bat_therm_fault_threshold_q);

    assign fault_d = die_fault_d || bus_fault_d || bat_fault_d;

    always @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            die_fault_o           <= 1'b0;
            bus_therm_fault_o     <= 1'b0;
            bat_therm_fault_o     <= 1'b0;
            any_fault_q           <= 1'b0;
            blocking_fet_off_o    <= 1'b0;
            switching_fet_off_o   <= 1'b0;
            charge_enable_clear_o <= 1'b0;
            host_int_n_o          <= 1'b1;
        end else begin
            die_fault_o         <= die_fault_d;
            bus_therm_fault_o   <= bus_fault_d;
            bat_therm_fault_o   <= bat_fault_d;
            any_fault_q         <= fault_d;
            // FETs stay off while any die or thermistor fault holds and turn back on in the cycle after it clears
            blocking_fet_off_o  <= fault_d;
            switching_fet_off_o <= fault_d;
            // Clear pulse only on onset so software may re-enable after recovery
            charge_enable_clear_o <= fault_d && !any_fault_q;
            host_int_n_o <= !die_alarm_d;
        end
    end

    // ****************************************
    // Input overvoltage and pulldowns
    // ****************************************
    wire in1_over;
    wire in2_over;

    tiopc_ovp_cmp u_in1_cmp (
        .ovp_code_i   (input_ovp_ctrl_q[`TIOPC_BIT_IN1_OVP_HI:`TIOPC_BIT_IN1_OVP_LO]),
        .voltage_mv_i (input1_voltage_i),
        .over_o       (in1_over)
    );

    tiopc_ovp_cmp u_in2_cmp (
        .ovp_code_i   (input_ovp_ctrl_q[`TIOPC_BIT_IN2_OVP_HI:`TIOPC_BIT_IN2_OVP_LO]),
        .voltage_mv_i (input2_voltage_i),
        .over_o       (in2_over)
    );

    always @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            input1_gate_driver_off_o <= 1'b0;
            input2_gate_driver_off_o <= 1'b0;
            input1_pulldown_on_o     <= 1'b0;
            input2_pulldown_on_o     <= 1'b0;
        end else begin
            input1_gate_driver_off_o <= in1_over;
            input2_gate_driver_off_o <= in2_over;
            // Follows the stored bit one cycle later, including after soft reset
            input1_pulldown_on_o <= input_ovp_ctrl_q[`TIOPC_BIT_IN1_PD];
            input2_pulldown_on_o <= input_ovp_ctrl_q[`TIOPC_BIT_IN2_PD];
        end
    end

endmodule // tiopc_top
`default_nettype wire

// [tb/tiopc_monitor.sv]
// Concurrent checks on the protection register bank ports
`default_nettype none
`include "tiopc_defs.vh"
module tiopc_monitor (
    input wire logic        ref_clk_i,
    input wire logic        nrst_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic [7:0]  reg_wdata_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [7:0]  reg_rdata_o,
    input wire logic        reg_rvalid_o,
    input wire logic [7:0]  die_temp_i,
    input wire logic [15:0] input1_voltage_i,
    input wire logic        blocking_fet_off_o,
    input wire logic        switching_fet_off_o,
    input wire logic        charge_enable_clear_o,
    input wire logic        input1_gate_driver_off_o,
    input wire logic        input1_pulldown_on_o,
    input wire logic        input2_pulldown_on_o,
    input wire logic        die_fault_o,
    input wire logic        bus_therm_fault_o,
    input wire logic        bat_therm_fault_o,
    input wire logic        reg_reset_done_o
);
    wire f_any  = die_fault_o | bus_therm_fault_o | bat_therm_fault_o;
    wire soft_w = reg_wr_i && reg_addr_i == `TIOPC_ADDR_CHG_CTRL2 && reg_wdata_i[7];
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    // ****************************************
    // Sequences and properties
    // ****************************************
    sequence s_read;
        reg_rd_i ##1 reg_rvalid_o;
    endsequence
    // Second step keeps a later write from moving the copy under test
    sequence s_pd_wr;
        reg_wr_i && reg_addr_i == `TIOPC_ADDR_OVP_CTRL ##1
        !(reg_wr_i && reg_addr_i inside {`TIOPC_ADDR_OVP_CTRL, `TIOPC_ADDR_CHG_CTRL2});
    endsequence
    property p_fet_pair; blocking_fet_off_o == switching_fet_off_o; endproperty
    property p_fet_any; blocking_fet_off_o == f_any; endproperty
    property p_clr; charge_enable_clear_o == $rose(f_any); endproperty
    property p_rd; reg_rd_i |-> s_read; endproperty
    property p_rv_src; reg_rvalid_o |-> $past(reg_rd_i); endproperty
    property p_rsvd;
        reg_rvalid_o && $past(reg_addr_i) == `TIOPC_ADDR_TEMP_CTRL |-> reg_rdata_o[1:0] == 2'b00;
    endproperty
    property p_done; reg_reset_done_o == $past(soft_w); endproperty
    property p_pd;
        s_pd_wr |=> {input1_pulldown_on_o, input2_pulldown_on_o} == $past(reg_wdata_i[1:0], 2);
    endproperty
    property p_g_lo; $past(input1_voltage_i) < `TIOPC_OVP_6V5 |-> !input1_gate_driver_off_o;
    endproperty
    property p_g_hi; $past(input1_voltage_i) >= `TIOPC_OVP_18V |-> input1_gate_driver_off_o;
    endproperty
    property p_die_lo; $past(die_temp_i) < `TIOPC_DIE_80C |-> !die_fault_o; endproperty
    a_fet_pair: assert property (p_fet_pair) else $error("fet outputs differ");
    a_fet_any: assert property (p_fet_any) else $error("fet off not any fault");
    a_clr: assert property (p_clr) else $error("clear pulse wrong");
    a_rd: assert property (p_rd) else $error("read not answered");
    a_rv_src: assert property (p_rv_src) else $error("stray read valid");
    a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
    a_done: assert property (p_done) else $error("soft reset pulse wrong");
    a_pd: assert property (p_pd) else $error("pulldown copy wrong");
    a_g_lo: assert property (p_g_lo) else $error("gate off below 6.5 V");
    a_g_hi: assert property (p_g_hi) else $error("gate on above 18 V");
    a_die_lo: assert property (p_die_lo) else $error("die fault below 80 C");
endmodule // tiopc_monitor
bind tiopc_top tiopc_monitor u_mon (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .die_temp_i(die_temp_i),
    .input1_voltage_i(input1_voltage_i), .blocking_fet_off_o(blocking_fet_off_o),
    .switching_fet_off_o(switching_fet_off_o), .charge_enable_clear_o(charge_enable_clear_o),
    .input1_gate_driver_off_o(input1_gate_driver_off_o),
    .input1_pulldown_on_o(input1_pulldown_on_o), .input2_pulldown_on_o(input2_pulldown_on_o),
    .die_fault_o(die_fault_o), .bus_therm_fault_o(bus_therm_fault_o),
    .bat_therm_fault_o(bat_therm_fault_o), .reg_reset_done_o(reg_reset_done_o)
);
`default_nettype wire

// [tb/tiopc_host.sv]
// Host model driving the byte register port
`default_nettype none
module tiopc_host (
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    output var  logic [7:0] addr_o,
    output var  logic [7:0] wdata_o,
    output var  logic       wr_o,
    output var  logic       rd_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        addr_o = 8'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    // Released bus shows inverted junk, so a late sample cannot pass
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
        @(negedge clk_i);
        d = rdata_i;
    endtask
endmodule // tiopc_host
`default_nettype wire

// [tb/tb_tiopc_top.sv]
// Self-checking bench for the protection register bank
`default_nettype none
`include "tiopc_defs.vh"
module tb_tiopc_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        ref_clk_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic [7:0]  die_t = 8'h00;
    logic [7:0]  bus_r = 8'hff;
    logic [7:0]  bat_r = 8'hff;
    logic [15:0] v1 = 16'h0000;
    logic [15:0] v2 = 16'h0000;
    logic [7:0]  rv, t;
    logic [7:0]  dflt [5] = '{8'h60, 8'hc8, 8'h15, 8'h15, 8'h00};
    wire  [7:0]  addr, wdata, rdata;
    wire         wr, rd, rvalid, blk, sw, clr, g1, g2, pd1, pd2, int_n, df, bf, tf, done;
    int          err_total = 0;
    int          checked = 0;
    always #25 ref_clk_i = ~ref_clk_i;
    tiopc_host host (.clk_i(ref_clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
        .wr_o(wr), .rd_o(rd));
    tiopc_top dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .reg_rvalid_o(rvalid), .die_temp_i(die_t), .bus_therm_ratio_i(bus_r),
        .bat_therm_ratio_i(bat_r), .input1_voltage_i(v1), .input2_voltage_i(v2),
        .blocking_fet_off_o(blk), .switching_fet_off_o(sw), .charge_enable_clear_o(clr),
        .input1_gate_driver_off_o(g1), .input2_gate_driver_off_o(g2),
        .input1_pulldown_on_o(pd1), .input2_pulldown_on_o(pd2), .host_int_n_o(int_n),
        .die_fault_o(df), .bus_therm_fault_o(bf), .bat_therm_fault_o(tf),
        .reg_reset_done_o(done));
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [7:0] die_lvl(input logic [1:0] c);
        return `TIOPC_DIE_80C + {6'h00, c} * 8'h28;
    endfunction
    function automatic logic [15:0] ovp_lvl(input logic [2:0] c);
        case (c)
            3'h0: return `TIOPC_OVP_6V5;
            3'h1: return `TIOPC_OVP_10V5;
            3'h2: return `TIOPC_OVP_12V;
            3'h3: return `TIOPC_OVP_14V;
            3'h4: return `TIOPC_OVP_16V;
            default: return `TIOPC_OVP_18V;
        endcase
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        host.rd_reg(a, rv);
        // Read data and its valid flag both stand in the half cycle after the read edge
        chk({7'h00, rvalid, rv}, {7'h00, 1'b1, e});
    endtask
    task automatic step;
        @(posedge ref_clk_i);
        @(negedge ref_clk_i);
    endtask
    task automatic set_in(input logic [7:0] d, bu, ba, input logic [15:0] a1, a2);
        @(posedge ref_clk_i);
        die_t <= d;
        bus_r <= bu;
        bat_r <= ba;
        v1 <= a1;
        v2 <= a2;
        step;
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Roughly two hundred cycles needed; generous margin
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        err_total++;
        complete_run;
    end
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        void'($urandom(11));
        repeat (8) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        for (int i = 0; i < 5; i++) rchk(8'h0a + 8'(i), dflt[i]);
        $display("test defaults done");
        for (int i = 0; i < 5; i++) begin
            t = 8'($urandom);
            host.wr_reg(8'h0a + 8'(i), t);
            rchk(8'h0a + 8'(i), (i == 0) ? (t & 8'hfc) : t);
        end
        host.wr_reg(8'h10, 8'hff);
        rchk(8'h10, 8'h00);
        $display("test access done");
        for (int c = 0; c < 4; c++) begin
            host.wr_reg(8'h0a, {1'b0, 2'(c), 5'h10});
            set_in(die_lvl(2'(c)) - 8'h01, 8'hff, 8'hff, 16'h0000, 16'h0000);
            chk({14'h0000, df, blk}, 16'h0000);
            set_in(die_lvl(2'(c)), 8'hff, 8'hff, 16'h0000, 16'h0000);
            chk({13'h0000, df, blk, clr}, 16'h0007);
        end
        host.wr_reg(8'h0a, 8'h90);
        set_in(8'hff, 8'hff, 8'hff, 16'h0000, 16'h0000);
        chk({14'h0000, df, sw}, 16'h0000);
        $display("test die fault done");
        t = 8'($urandom_range(254, 1));
        host.wr_reg(8'h0a, 8'h80);
        host.wr_reg(8'h0b, t);
        set_in(t - 8'h01, 8'hff, 8'hff, 16'h0000, 16'h0000);
        chk({15'h0000, int_n}, 16'h0001);
        set_in(t, 8'hff, 8'hff, 16'h0000, 16'h0000);
        chk({15'h0000, int_n}, 16'h0000);
        host.wr_reg(8'h0a, 8'h90);
        step;
        chk({15'h0000, int_n}, 16'h0001);
        $display("test alarm done");
        for (int ch = 0; ch < 2; ch++) begin
            t = 8'($urandom_range(255, 1));
            host.wr_reg(8'h0a, 8'h90);
            host.wr_reg(8'h0c + 8'(ch), t);
            set_in(8'h00, ch ? 8'hff : t, ch ? t : 8'hff, 16'h0000, 16'h0000);
            chk({14'h0000, bf, tf}, 16'h0000);
            set_in(8'h00, ch ? 8'hff : t - 8'h01, ch ? t - 8'h01 : 8'hff, 16'h0000, 16'h0000);
            chk({12'h000, bf, tf, blk, clr}, ch ? 16'h0007 : 16'h000b);
            host.wr_reg(8'h0a, ch ? 8'h94 : 8'h98);
            step;
            chk({13'h0000, bf, tf, blk}, 16'h0000);
        end
        $display("test thermistor done");
        for (int c = 0; c < 8; c++) begin
            host.wr_reg(8'h0e, {3'(c), 3'(7 - c), 2'(c)});
            set_in(8'h00, 8'hff, 8'hff, ovp_lvl(3'(c)) - 16'h0001, ovp_lvl(3'(7 - c)));
            chk({12'h000, g1, g2, pd1, pd2}, {12'h000, 2'b01, 2'(c)});
            set_in(8'h00, 8'hff, 8'hff, ovp_lvl(3'(c)), ovp_lvl(3'(7 - c)) - 16'h0001);
            chk({14'h0000, g1, g2}, 16'h0002);
        end
        $display("test overvoltage done");
        host.wr_reg(8'h0f, 8'h80);
        @(negedge ref_clk_i);
        chk({15'h0000, done}, 16'h0001);
        for (int i = 0; i < 5; i++) rchk(8'h0a + 8'(i), dflt[i]);
        rchk(8'h0f, 8'h00);
        chk({15'h0000, done}, 16'h0000);
        chk({14'h0000, pd1, pd2}, 16'h0000);
        $display("test soft reset done");
        complete_run;
    end
endmodule // tb_tiopc_top
`default_nettype wire
